// >>> flash_array_model.sv
// Behavioural flash array that answers reads and obeys program/erase commands
`default_nettype none
module flash_array_model
  import flash_guard_pkg::*;
(
  // Clock
  input  wire logic                      clk_i,
  // Command from the guard and read port
  input  wire flash_guard_pkg::arr_cmd_t arr_i,
  input  wire logic [15:0]               addr_i,
  output logic [15:0]                    rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] mem [512];

  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
  end

  assign rdata_o = mem[addr_i[9:1]];

  // Programming only clears bits; erase restores a 64-word segment to ones
  always @(posedge clk_i) begin
    if (arr_i.wr) begin
      mem[arr_i.addr[9:1]] <= mem[arr_i.addr[9:1]] & arr_i.data;
    end
    if (arr_i.erase) begin
      for (int i = 0; i < 512; i++) begin
        if (i[8:6] == arr_i.addr[9:7]) mem[i] <= 16'hffff;
      end
    end
  end
endmodule : flash_array_model
`default_nettype wire

// >>> flash_guard_pkg.sv
// Shared constants and carrier types of the flash access guard
`default_nettype none
package flash_guard_pkg;

  // Opcodes seen on the instruction path
  localparam logic [15:0] SPIN_OPCODE    = 16'h3fff;
  localparam logic [15:0] RETURN_OPCODE  = 16'h0000; // Arbitrary default

  // Block geometry: 64 bytes held as 32 words
  localparam int          BLOCK_WORDS    = 32;
  localparam int          WCOUNT_W       = 6;

  // Timing, in timing_generator_clock ticks
  localparam int          TICK_W         = 16;
  localparam logic [15:0] WORD_TICKS     = 16'h001e;
  localparam logic [15:0] ERASE_TICKS    = 16'h03e8;
  localparam logic [15:0] END_TICKS      = 16'h0006;
  localparam logic [5:0]  SLICE_TICKS    = 6'h20;

  // Timing generator divider, in system clock cycles
  localparam int          DIV_W          = 8;
  localparam logic [7:0]  FTG_DIV_RESET  = 8'h04;

  // Controller states
  typedef enum logic [6:0] {
    S_IDLE    = 7'b0000001,
    S_WORD    = 7'b0000010,
    S_BLKPROG = 7'b0000100,
    S_BLKWAIT = 7'b0001000,
    S_BLKEND  = 7'b0010000,
    S_ERASE   = 7'b0100000,
    S_ESUSP   = 7'b1000000
  } state_t;

  // Processor access to the flash address range
  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic        in_flash;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cpu_req_t;

  // Answer to a processor read or fetch
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } cpu_rsp_t;

  // Command to the flash array
  typedef struct packed {
    logic        wr;
    logic        erase;
    logic [15:0] addr;
    logic [15:0] data;
  } arr_cmd_t;

endpackage : flash_guard_pkg
`default_nettype wire

// >>> flash_op_timer.sv
// Timing generator divider and operation duration counter
`default_nettype none
module flash_op_timer #(
  parameter int DIV_W = 8,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] load_val_i,
  input  wire logic             run_i,
  // Status
  output logic                  tick_o,
  output logic                  done_o
);

  logic [DIV_W-1:0] div_reg;
  logic [CNT_W-1:0] cnt_reg;

  // Timing generator tick: one pulse every div_i system clocks
  always_ff @(posedge clk_i) begin
    if (rst_i || div_reg == '0) begin
      div_reg <= (div_i == '0) ? '0 : div_i - 1'b1;
      tick_o  <= !rst_i;
    end else begin
      div_reg <= div_reg - 1'b1;
      tick_o  <= 1'b0;
    end
  end

  // Duration counter, paused while run_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      done_o  <= 1'b0;
    end else if (load_i) begin
      cnt_reg <= load_val_i;
      done_o  <= 1'b0;
    end else if (run_i && tick_o && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
      done_o  <= (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});
    end else begin
      done_o  <= 1'b0;
    end
  end

endmodule : flash_op_timer
`default_nettype wire

// >>> flash_program_access_guard.sv
// Flash write/erase sequencer and processor access guard
//
// Behaviour
// (R1) Programming voltage stays on for whole block
// (R2) Block programming is started only from RAM
// (R3) Busy spans the block, clears at block end
// (R4) Next-word-ready paces block writes
// (R5) Host clears block mode, waits recovery time
// (R6) Host avoids flash while busy from RAM
// (R7) Write without program enable flags, no change
// (R8) Fetch during flash-started op returns spin
// (R9) Real fetch data returns once not busy
// (R10) Busy data reads return spin, no flag
// (R11) Write during erase or word program flags
// (R12) Bad block-mode access sets flag and inhibit
// (R13) Ready block write is programmed, no flag
// (R14) Interrupts masked during op unless enabled
// (R15) Abort mode: interrupt ends op, abort flag
// (R16) Segment erase yields every 32 ticks
// (R17) Suspended erase: busy, accesses allowed
// (R18) Return opcode ends service; no nesting
// (R19) Reset aborts any operation in progress
// (R20) Violation flag cleared only by processor
// (R21) Enable bits select word or block mode
// (R22) Ready drops after each accepted block write
`default_nettype none
module flash_program_access_guard
  import flash_guard_pkg::*;
#(
  parameter logic [15:0] WORD_T   = WORD_TICKS,
  parameter logic [15:0] ERASE_T  = ERASE_TICKS,
  parameter logic [15:0] END_T    = END_TICKS,
  parameter logic [15:0] RET_CODE = RETURN_OPCODE,
  parameter int          N_WORDS  = BLOCK_WORDS
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Processor access and answer
  input  wire flash_guard_pkg::cpu_req_t req_i,
  output flash_guard_pkg::cpu_rsp_t     rsp_o,
  // Flash array
  input  wire logic [15:0]              array_rdata_i,
  output flash_guard_pkg::arr_cmd_t     arr_o,
  // Control bits
  input  wire logic                     program_enable_i,
  input  wire logic                     block_program_mode_i,
  input  wire logic                     erase_mode_i,
  input  wire logic                     erase_interrupt_allow_i,
  input  wire logic                     interrupt_abort_enable_i,
  input  wire logic                     global_irq_enable_i,
  input  wire logic [7:0]               ftg_div_i,
  input  wire logic                     viol_clear_i,
  input  wire logic                     inhibit_clear_i,
  input  wire logic                     abort_clear_i,
  // Interrupt side
  input  wire logic                     irq_pending_i,
  output logic                          irq_mask_o,
  // Status
  output logic                          busy_o,
  output logic                          next_word_ready_o,
  output logic                          access_violation_flag_o,
  output logic                          program_inhibit_o,
  output logic                          abort_flag_o,
  output logic                          prog_voltage_o
);

  import flash_guard_pkg::*;

  state_t               state_reg;
  state_t               state_next;
  logic [WCOUNT_W-1:0]  wcount_reg;
  logic [5:0]           slice_reg;
  logic                 tick;
  logic                 op_done;
  logic                 tmr_load;
  logic [TICK_W-1:0]    tmr_val;
  logic                 tmr_run;

  logic acc, acc_wr, acc_rd, busy, svc, blk, start;
  logic blk_accept, viol_ev, inhibit_ev, abort_ev;
  logic yield_mode, yield_ev, resume_ev, spin;

  // Access decode
  assign acc    = req_i.valid && req_i.in_flash;
  assign acc_wr = acc && req_i.write && !req_i.fetch;
  assign acc_rd = acc && !req_i.write;
  assign busy   = (state_reg != S_IDLE);
  assign svc    = (state_reg == S_ESUSP);
  assign blk    = (state_reg == S_BLKPROG) || (state_reg == S_BLKWAIT) ||
                  (state_reg == S_BLKEND);
  assign spin   = busy && !svc; // R8 R10

  assign start      = !busy && acc_wr && program_enable_i; // R21
  assign blk_accept = (state_reg == S_BLKWAIT) && next_word_ready_o &&
                      acc_wr; // R13
  assign abort_ev   = busy && interrupt_abort_enable_i &&
                      global_irq_enable_i && irq_pending_i; // R15
  assign yield_mode = erase_interrupt_allow_i && global_irq_enable_i &&
                      !interrupt_abort_enable_i;
  assign yield_ev   = (state_reg == S_ERASE) && yield_mode &&
                      slice_reg == '0 && irq_pending_i && !op_done; // R16
  assign resume_ev  = svc && acc && req_i.fetch &&
                      array_rdata_i == RET_CODE; // R18

  // Violations by mode, while idle or busy
  assign inhibit_ev = blk && acc &&
                      (!next_word_ready_o || req_i.fetch); // R12
  always_comb begin
    viol_ev = 1'b0;
    if (!busy) begin
      viol_ev = acc_wr && !program_enable_i; // R7
    end else if (blk) begin
      viol_ev = inhibit_ev; // R12
    end else if (!svc) begin
      viol_ev = acc_wr; // R11
    end
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (start) begin
          if (erase_mode_i) begin
            state_next = S_ERASE;
          end else if (block_program_mode_i) begin
            state_next = S_BLKPROG; // R21
          end else begin
            state_next = S_WORD;
          end
        end
      end
      S_WORD: begin
        if (op_done) begin
          state_next = S_IDLE;
        end
      end
      S_BLKPROG: begin
        if (op_done) begin
          state_next = (wcount_reg >= N_WORDS[WCOUNT_W-1:0]) ?
                       S_BLKEND : S_BLKWAIT;
        end
      end
      S_BLKWAIT: begin
        if (blk_accept) begin
          state_next = S_BLKPROG; // R22
        end else if (!block_program_mode_i) begin
          state_next = S_BLKEND;
        end
      end
      S_BLKEND: begin
        if (op_done) begin
          state_next = S_IDLE; // R3
        end
      end
      S_ERASE: begin
        if (op_done) begin
          state_next = S_IDLE;
        end else if (yield_ev) begin
          state_next = S_ESUSP; // R16
        end
      end
      S_ESUSP: begin
        if (resume_ev) begin
          state_next = S_ERASE; // R18
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    if (abort_ev) begin
      state_next = S_IDLE; // R15
    end
  end

  // State register; reset drops any operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE; // R19
    end else begin
      state_reg <= state_next;
    end
  end

  // Duration timer load and run
  assign tmr_load = (state_next != state_reg) &&
                    (state_next != S_IDLE) && (state_next != S_BLKWAIT) &&
                    (state_next != S_ESUSP) && (state_reg != S_ESUSP);
  always_comb begin
    case (state_next)
      S_ERASE:  tmr_val = ERASE_T;
      S_BLKEND: tmr_val = END_T;
      default:  tmr_val = WORD_T;
    endcase
  end
  assign tmr_run = (state_reg == S_WORD) || (state_reg == S_BLKPROG) ||
                   (state_reg == S_BLKEND) || (state_reg == S_ERASE);

  flash_op_timer #(
    .DIV_W (DIV_W),
    .CNT_W (TICK_W)
  ) u_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .div_i      (ftg_div_i),
    .load_i     (tmr_load),
    .load_val_i (tmr_val),
    .run_i      (tmr_run),
    .tick_o     (tick),
    .done_o     (op_done)
  );

  // Words written in the current block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wcount_reg <= '0;
    end else if (start) begin
      wcount_reg <= {{(WCOUNT_W-1){1'b0}}, 1'b1};
    end else if (blk_accept) begin
      wcount_reg <= wcount_reg + 1'b1;
    end
  end

  // Erase slice: guaranteed ticks before a yield
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slice_reg <= SLICE_TICKS;
    end else if (state_reg != S_ERASE) begin
      slice_reg <= SLICE_TICKS; // R16
    end else if (tick && slice_reg != '0) begin
      slice_reg <= slice_reg - 1'b1;
    end
  end

  // Status outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o            <= 1'b0;
      next_word_ready_o <= 1'b0;
      prog_voltage_o    <= 1'b0;
      irq_mask_o        <= 1'b0;
    end else begin
      busy_o            <= (state_next != S_IDLE); // R3 R17
      next_word_ready_o <= (state_next == S_BLKWAIT); // R4 R22
      prog_voltage_o    <= (state_next == S_WORD) ||
                           (state_next == S_BLKPROG) ||
                           (state_next == S_BLKWAIT); // R1
      irq_mask_o        <= (state_next != S_IDLE) &&
                           (state_next != S_ESUSP) &&
                           !(interrupt_abort_enable_i &&
                             global_irq_enable_i); // R14
    end
  end

  // Sticky flags: a new event wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      access_violation_flag_o <= 1'b0;
    end else if (viol_ev) begin
      access_violation_flag_o <= 1'b1;
    end else if (viol_clear_i) begin
      access_violation_flag_o <= 1'b0; // R20
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_inhibit_o <= 1'b0;
    end else if (inhibit_ev) begin
      program_inhibit_o <= 1'b1; // R12
    end else if (inhibit_clear_i) begin
      program_inhibit_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      abort_flag_o <= 1'b0;
    end else if (abort_ev) begin
      abort_flag_o <= 1'b1; // R15
    end else if (abort_clear_i) begin
      abort_flag_o <= 1'b0;
    end
  end

  // Read and fetch answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= acc_rd;
      rsp_o.data  <= spin ? SPIN_OPCODE : array_rdata_i; // R8 R9 R10
    end
  end

  // Array commands; discarded writes never reach the array
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arr_o <= '0;
    end else begin
      arr_o.wr    <= (start && !erase_mode_i) || blk_accept; // R13
      arr_o.erase <= start && erase_mode_i;
      arr_o.addr  <= req_i.addr;
      arr_o.data  <= req_i.wdata;
    end
  end

  // Checks
  sequence s_busy_fetch;
    acc && req_i.fetch && busy && !svc;
  endsequence

  sequence s_yield_cond;
    yield_ev && !abort_ev;
  endsequence

  a_spin_fetch: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    s_busy_fetch |=> rsp_o.valid && rsp_o.data == SPIN_OPCODE)
    else $error("busy fetch did not return spin opcode");
  a_real_fetch: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    acc_rd && !busy |=> rsp_o.data == $past(array_rdata_i))
    else $error("idle read did not return array data");
  a_read_noflag: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    acc_rd && busy && !blk && !svc && !viol_clear_i
      |=> rsp_o.data == SPIN_OPCODE &&
          access_violation_flag_o == $past(access_violation_flag_o))
    else $error("busy read returned data or set the flag");
  a_no_enable_wr: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    acc_wr && !busy && !program_enable_i
      |=> access_violation_flag_o && !arr_o.wr)
    else $error("write without enable not flagged or reached array");
  a_word_discard: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    acc_wr && (state_reg == S_WORD || state_reg == S_ERASE)
      |=> access_violation_flag_o && !arr_o.wr)
    else $error("write during operation not discarded");
  a_blk_inhibit: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    inhibit_ev |=> access_violation_flag_o && program_inhibit_o)
    else $error("bad block access missed flag or inhibit");
  a_blk_accept: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    blk_accept && !abort_ev
      |=> arr_o.wr && !next_word_ready_o && busy_o && prog_voltage_o)
    else $error("block write not programmed or ready held");
  a_abort_op: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    abort_ev |=> !busy_o && abort_flag_o ##1 !busy_o)
    else $error("interrupt did not abort operation");
  a_erase_yield: assert property (@(posedge clk_i) // R16 R17
    disable iff (rst_i) s_yield_cond |=> busy_o && !irq_mask_o)
    else $error("segment erase did not yield to interrupt");
  a_slice_guard: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    $rose(state_reg == S_ERASE) |-> slice_reg == SLICE_TICKS)
    else $error("resumed erase lacks full slice");
  a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    busy && !svc && $past(busy) &&
    !$past(interrupt_abort_enable_i) |-> irq_mask_o)
    else $error("interrupts not masked during operation");

endmodule : flash_program_access_guard
`default_nettype wire

// >>> flash_program_access_guard_bench.sv
// Self-checking bench for the flash access guard
`default_nettype none
module flash_program_access_guard_bench;
  import flash_guard_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] RET = 16'h1300; // Arbitrary return opcode

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  cpu_req_t    req   = '0;
  cpu_rsp_t    rsp;
  arr_cmd_t    arr;
  logic [15:0] rdata;
  logic        pe = 1'b0, bpm = 1'b0, em = 1'b0;
  logic        erase_interrupt_allow = 1'b0, interrupt_abort_enable = 1'b0, global_irq_enable = 1'b0;
  logic        vclr = 1'b0, iclr = 1'b0, aclr = 1'b0, irq = 1'b0;
  logic        mask, busy, rdy, viol, inh, abt, volt;
  int          failures = 0;
  int          tests_run = 0;
  logic [15:0] got;
  int          n;

  always #5 clk_i = ~clk_i;

  flash_program_access_guard #(
    .WORD_T(16'h0014), .ERASE_T(16'h0050), .END_T(16'h0002),
    .RET_CODE(RET), .N_WORDS(32)
  ) flash_program_access_guard_i (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp),
    .array_rdata_i(rdata), .arr_o(arr), .program_enable_i(pe),
    .block_program_mode_i(bpm), .erase_mode_i(em),
    .erase_interrupt_allow_i(erase_interrupt_allow), .interrupt_abort_enable_i(interrupt_abort_enable),
    .global_irq_enable_i(global_irq_enable), .ftg_div_i(8'h01), .viol_clear_i(vclr),
    .inhibit_clear_i(iclr), .abort_clear_i(aclr), .irq_pending_i(irq),
    .irq_mask_o(mask), .busy_o(busy), .next_word_ready_o(rdy),
    .access_violation_flag_o(viol), .program_inhibit_o(inh),
    .abort_flag_o(abt), .prog_voltage_o(volt)
  );

  flash_array_model flash_array_model_i (
    .clk_i(clk_i), .arr_i(arr), .addr_i(req.addr), .rdata_o(rdata)
  );

  task automatic give_verdict();
    $display("Counts: tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One access, held for one edge; read data is taken where it stands
  task automatic access(input logic f, w, input logic [15:0] a, d);
    @(negedge clk_i);
    req <= '{1'b1, f, w, 1'b1, a, d};
    @(negedge clk_i);
    req <= '0;
    got = rsp.valid ? rsp.data : 16'hxxxx;
  endtask : access

  task automatic wait_for(input int sel, input logic lvl, output int cyc);
    cyc = 0;
    while ((sel == 0 ? busy : sel == 1 ? rdy : mask) !== lvl) begin
      @(negedge clk_i);
      cyc++;
      if (cyc > 5000) begin
        failures++;
        give_verdict();
      end
    end
  endtask : wait_for

  task automatic clear_flags();
    @(negedge clk_i);
    {vclr, iclr, aclr} <= 3'b111;
    @(negedge clk_i);
    {vclr, iclr, aclr} <= 3'b000;
  endtask : clear_flags

  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    check({busy, rdy, viol, inh, abt, volt, mask}, 16'h0000);
    rst_i <= 1'b0;
    // Write with programming disabled
    access(0, 1, 16'h0004, 16'h0000);
    check(viol, 1);
    access(0, 0, 16'h0004, 16'h0000);
    check(got, 16'hffff);
    repeat (20) @(negedge clk_i);
    check(viol, 1);
    clear_flags();
    check(viol, 0);
    // Word program with accesses while busy
    pe <= 1'b1;
    access(0, 1, 16'h0004, 16'h1234);
    check(busy, 1);
    check(mask, 1);
    access(1, 0, 16'h0004, 16'h0000);
    check(got, SPIN_OPCODE);
    access(0, 0, 16'h0004, 16'h0000);
    check(got, SPIN_OPCODE);
    check(viol, 0);
    access(0, 1, 16'h0006, 16'h0000);
    check(viol, 1);
    wait_for(0, 0, n);
    check(mask, 0);
    access(1, 0, 16'h0004, 16'h0000);
    check(got, 16'h1234);
    access(0, 0, 16'h0006, 16'h0000);
    check(got, 16'hffff);
    clear_flags();
    // Full block of 32 words
    bpm <= 1'b1;
    access(0, 1, 16'h0040, 16'ha000);
    check(rdy, 0);
    check(volt, 1);
    for (int i = 1; i < 32; i++) begin
      wait_for(1, 1, n);
      check(volt, 1);
      check(busy, 1);
      if (i == 5) begin
        access(0, 0, 16'h0040, 16'h0000);
        check(got, SPIN_OPCODE);
        check(viol, 0);
      end
      access(0, 1, 16'h0040 + 16'(2 * i), 16'ha000 + 16'(i));
      check(rdy, 0);
      check(viol, 0);
    end
    wait_for(0, 0, n);
    check(volt, 0);
    check(busy, 0);
    bpm <= 1'b0;
    repeat (10) @(negedge clk_i);
    access(0, 0, 16'h0040, 16'h0000);
    check(got, 16'ha000);
    access(0, 0, 16'h007e, 16'h0000);
    check(got, 16'ha01f);
    // Short block with violations, ended by leaving block mode
    bpm <= 1'b1;
    access(0, 1, 16'h0100, RET);
    access(0, 0, 16'h0100, 16'h0000);
    check({viol, inh}, 2'b11);
    clear_flags();
    wait_for(1, 1, n);
    access(1, 0, 16'h0100, 16'h0000);
    check({viol, inh}, 2'b11);
    clear_flags();
    bpm <= 1'b0;
    wait_for(0, 0, n);
    check(busy, 0);
    access(0, 0, 16'h0100, 16'h0000);
    check(got, RET);
    // Erase cut short by an interrupt in abort mode
    {em, interrupt_abort_enable, global_irq_enable} <= 3'b111;
    access(0, 1, 16'h0200, 16'h0000);
    check(mask, 0);
    check(busy, 1);
    irq <= 1'b1;
    @(negedge clk_i);
    check(busy, 0);
    check(abt, 1);
    irq <= 1'b0;
    clear_flags();
    // Erase that yields to an interrupt and resumes on return
    {interrupt_abort_enable, erase_interrupt_allow} <= 2'b01;
    irq <= 1'b1;
    access(0, 1, 16'h0200, 16'h0000);
    check(mask, 1);
    wait_for(2, 0, n);
    check(16'(n >= 28 && n <= 34), 1);
    check(busy, 1);
    access(0, 0, 16'h0040, 16'h0000);
    check(got, 16'ha000);
    check(viol, 0);
    irq <= 1'b0;
    access(1, 0, 16'h0100, 16'h0000);
    check(got, RET);
    check(mask, 1);
    check(busy, 1);
    wait_for(0, 0, n);
    check(16'(n >= 32), 1);
    // Reset in mid-erase
    erase_interrupt_allow <= 1'b0;
    access(0, 1, 16'h0200, 16'h0000);
    repeat (5) @(negedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    check({busy, mask, volt}, 3'b000);
    give_verdict();
  end
endmodule : flash_program_access_guard_bench
`default_nettype wire
